// *** design/adp_top.sv ***
// Converter pair sequencer: register slave, triggers, sampling and SAR conversion
`timescale 1ns/1ps
module adp_top
   import adp_pkg::*;
#(
   parameter int NUM_PAIRS = 6,
   parameter int NUM_TRIG = 8
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [DATA_W-1:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [NUM_TRIG-1:0] trig_in,
   input wire logic comp_in,
   output logic sample_hold,
   output logic conv_active,
   output logic [3:0] conv_channel,
   output logic [RES_W-1:0] sar_trial,
   output logic irq
);

   localparam int NUM_CH = 2 * NUM_PAIRS;

   // ---------------------------------------------------------------
   // Elaboration checks
   // ---------------------------------------------------------------
   if (NUM_PAIRS < 1 || NUM_PAIRS > 8) begin : g_bad_pairs
      $error("NUM_PAIRS must lie between 1 and 8");
   end
   if (NUM_TRIG < 1 || NUM_TRIG > 8) begin : g_bad_trig
      $error("NUM_TRIG must lie between 1 and 8");
   end

   // ---------------------------------------------------------------
   // Helpers
   // ---------------------------------------------------------------
   function automatic logic [15:0] be_merge(input logic [15:0] old, input logic [DATA_W-1:0] wd,
                                            input logic [3:0] be, input logic [15:0] wmask);
      logic [15:0] nv;
      nv = old;
      if (be[0]) begin
         nv[7:0] = wd[7:0];
      end
      if (be[1]) begin
         nv[15:8] = wd[15:8];
      end
      return (nv & wmask) | (old & ~wmask);
   endfunction

   function automatic logic [2:0] lowest_set(input logic [7:0] v);
      logic [2:0] idx;
      idx = 3'h0;
      for (int i = 7; i >= 0; i--) begin
         if (v[i]) begin
            idx = 3'(i);
         end
      end
      return idx;
   endfunction

   // ---------------------------------------------------------------
   // Registers
   // ---------------------------------------------------------------
   logic [15:0] ctrl_q;
   logic [7:0] pcfg_q [NUM_PAIRS];
   logic [NUM_PAIRS-1:0] stat_q;
   logic [NUM_PAIRS-1:0] mask_q;
   logic [NUM_PAIRS-1:0] pend_q;
   logic [RES_W-1:0] res_q [NUM_CH];
   logic rd_ack_q;
   logic [DATA_W-1:0] rdata_q;

   wire logic converter_on;
   wire logic pll_in_use;
   wire logic [DIV_W-1:0] conv_clock_divisor;
   wire logic conv_tick;

   assign converter_on = ctrl_q[CTRL_ON_BIT];
   assign pll_in_use = ctrl_q[CTRL_PLL_BIT];
   assign conv_clock_divisor = ctrl_q[CTRL_DIV_LSB +: DIV_W];

   adp_clkdiv u_clkdiv (
      .sys_clk(sys_clk),
      .rst(rst),
      .converter_on(converter_on),
      .pll_in_use(pll_in_use),
      .conv_clock_divisor(conv_clock_divisor),
      .conv_tick(conv_tick)
   );

   // ---------------------------------------------------------------
   // Bus decode
   // ---------------------------------------------------------------
   wire logic sel_ctrl;
   wire logic sel_stat;
   wire logic sel_mask;
   wire logic sel_pend;
   wire logic sel_pair;
   wire logic sel_res;
   wire logic [2:0] pair_idx;
   wire logic [3:0] res_idx;
   wire logic wr_en;
   wire logic rd_take;
   wire logic rd_done;
   logic [DATA_W-1:0] rd_word;

   assign sel_ctrl = (avs_address == OFS_CTRL);
   assign sel_stat = (avs_address == OFS_STAT);
   assign sel_mask = (avs_address == OFS_MASK);
   assign sel_pend = (avs_address == OFS_PEND);
   assign pair_idx = avs_address[4:2];
   assign res_idx = avs_address[5:2];
   assign sel_pair = (avs_address[7:5] == PAIR_BLOCK) && (avs_address[1:0] == 2'h0) && (int'(pair_idx) < NUM_PAIRS);
   assign sel_res = (avs_address[7:6] == RES_BLOCK) && (avs_address[1:0] == 2'h0) && (int'(res_idx) < NUM_CH);
   // Writes finish at once; reads take one wait cycle so read data come from a flip-flop
   assign wr_en = avs_write & ~avs_read;
   assign rd_take = avs_read & ~rd_ack_q;
   assign rd_done = avs_read & rd_ack_q;
   assign avs_waitrequest = avs_read & ~rd_ack_q;
   assign avs_readdata = rdata_q;

   always_comb begin
      rd_word = '0;
      if (sel_ctrl) begin
         rd_word[15:0] = ctrl_q;
      end else if (sel_stat) begin
         rd_word[NUM_PAIRS-1:0] = stat_q;
      end else if (sel_mask) begin
         rd_word[NUM_PAIRS-1:0] = mask_q;
      end else if (sel_pend) begin
         rd_word[NUM_PAIRS-1:0] = pend_q;
      end else if (sel_pair) begin
         rd_word[7:0] = pcfg_q[pair_idx];
      end else if (sel_res) begin
         rd_word[RES_W-1:0] = res_q[res_idx];
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         rd_ack_q <= 1'b0;
         rdata_q <= '0;
      end else begin
         rd_ack_q <= rd_take;
         if (rd_take) begin
            rdata_q <= rd_word;
         end
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         ctrl_q <= CTRL_RESET;
         mask_q <= '0;
      end else if (wr_en) begin
         if (sel_ctrl) begin
            ctrl_q <= be_merge(ctrl_q, avs_writedata, avs_byteenable, CTRL_WMASK);
         end
         if (sel_mask && avs_byteenable[0]) begin
            mask_q <= avs_writedata[NUM_PAIRS-1:0];
         end
      end
   end

   for (genvar p = 0; p < NUM_PAIRS; p++) begin : g_pcfg
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            pcfg_q[p] <= PCFG_RESET;
         end else if (wr_en && sel_pair && (int'(pair_idx) == p) && avs_byteenable[0]) begin
            pcfg_q[p] <= avs_writedata[7:0] & PCFG_WMASK;
         end
      end
   end

   // ---------------------------------------------------------------
   // Pin synchronisers
   // ---------------------------------------------------------------
   logic [NUM_TRIG:0] s1_q;
   logic [NUM_TRIG:0] s2_q;
   logic [NUM_TRIG:0] s3_q;
   logic [NUM_TRIG:0] lvl_q;
   wire logic [NUM_TRIG:0] lvl_d;
   wire logic [NUM_TRIG-1:0] trig_rise;
   wire logic comp_now;

   // A level counts only once the second and third stage agree
   assign lvl_d = (s2_q & s3_q) | (lvl_q & (s2_q ^ s3_q));
   assign trig_rise = lvl_d[NUM_TRIG-1:0] & ~lvl_q[NUM_TRIG-1:0];
   assign comp_now = lvl_d[NUM_TRIG];

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         s1_q <= '0;
         s2_q <= '0;
         s3_q <= '0;
         lvl_q <= '0;
      end else begin
         s1_q <= {comp_in, trig_in};
         s2_q <= s1_q;
         s3_q <= s2_q;
         lvl_q <= lvl_d;
      end
   end

   // ---------------------------------------------------------------
   // Sequencer
   // ---------------------------------------------------------------
   adp_seq_state_type state_q;
   logic [1:0] smp_cnt_q;
   logic [3:0] bit_q;
   logic side_q;
   logic [2:0] pair_q;
   logic [RES_W-1:0] code_q;

   logic [NUM_PAIRS-1:0] trig_evt;
   logic [7:0] pend_wide;
   logic [7:0] rise_wide;
   wire logic start;
   wire logic [2:0] grant;
   wire logic [NUM_PAIRS-1:0] grant_clr;
   wire logic [RES_W-1:0] bit_mask;
   wire logic [RES_W-1:0] resolved;
   wire logic bit_tick;
   wire logic last_bit;
   wire logic pair_done;
   wire logic [3:0] cur_ch;

   always_comb begin
      trig_evt = '0;
      pend_wide = '0;
      // Select codes beyond the last trigger pin see a quiet source
      rise_wide = '0;
      rise_wide[NUM_TRIG-1:0] = trig_rise;
      for (int p = 0; p < NUM_PAIRS; p++) begin
         trig_evt[p] = pcfg_q[p][PCFG_EN_BIT] && rise_wide[pcfg_q[p][PCFG_SEL_LSB +: SEL_W]];
         pend_wide[p] = pend_q[p];
      end
   end

   assign start = (state_q == SEQ_IDLE) && conv_tick && (pend_q != '0);
   assign grant = lowest_set(pend_wide);
   assign grant_clr = start ? NUM_PAIRS'(1) << grant : '0;
   assign bit_mask = RES_W'(1) << bit_q;
   assign resolved = comp_now ? code_q : (code_q & ~bit_mask);
   assign bit_tick = (state_q == SEQ_CONV) && conv_tick;
   assign last_bit = (bit_q == 4'h0);
   assign pair_done = bit_tick && last_bit && side_q;
   assign cur_ch = {pair_q, side_q};

   // A trigger landing in the cycle its pair is granted counts as a fresh request
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         pend_q <= '0;
      end else if (!converter_on) begin
         pend_q <= '0;
      end else begin
         pend_q <= (pend_q & ~grant_clr) | trig_evt;
      end
   end

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         state_q <= SEQ_IDLE;
         smp_cnt_q <= '0;
         bit_q <= '0;
         side_q <= 1'b0;
         pair_q <= '0;
         code_q <= RES_ZERO;
      end else if (!converter_on) begin
         state_q <= SEQ_IDLE;
      end else if (conv_tick) begin
         unique case (state_q)
            SEQ_IDLE: begin
               if (start) begin
                  state_q <= SEQ_SAMPLE;
                  pair_q <= grant;
                  side_q <= 1'b0;
                  smp_cnt_q <= '0;
               end
            end
            SEQ_SAMPLE: begin
               smp_cnt_q <= smp_cnt_q + 2'h1;
               if (smp_cnt_q == SAMPLE_CLKS - 2'h1) begin
                  state_q <= SEQ_CONV;
                  side_q <= 1'b0;
                  bit_q <= MSB_INDEX;
                  code_q <= RES_ZERO | (RES_W'(1) << MSB_INDEX);
               end
            end
            SEQ_CONV: begin
               if (!last_bit) begin
                  bit_q <= bit_q - 4'h1;
                  code_q <= resolved | (RES_W'(1) << (bit_q - 4'h1));
               end else if (!side_q) begin
                  side_q <= 1'b1;
                  bit_q <= MSB_INDEX;
                  code_q <= RES_ZERO | (RES_W'(1) << MSB_INDEX);
               end else begin
                  state_q <= SEQ_IDLE;
               end
            end
         endcase
      end
   end

   for (genvar c = 0; c < NUM_CH; c++) begin : g_res
      always_ff @(posedge sys_clk or posedge rst) begin
         if (rst) begin
            res_q[c] <= RES_ZERO;
         end else if (bit_tick && last_bit && (int'(cur_ch) == c)) begin
            res_q[c] <= resolved;
         end
      end
   end

   // ---------------------------------------------------------------
   // Interrupt status
   // ---------------------------------------------------------------
   wire logic [NUM_PAIRS-1:0] stat_set;
   wire logic [NUM_PAIRS-1:0] stat_clr;

   assign stat_set = pair_done ? NUM_PAIRS'(1) << pair_q : '0;
   // Clear only what the read returned, so an event landing in the wait cycle survives
   assign stat_clr = (rd_done && sel_stat) ? rdata_q[NUM_PAIRS-1:0] : '0;

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         stat_q <= '0;
      end else begin
         stat_q <= (stat_q & ~stat_clr) | stat_set;
      end
   end

   assign irq = |(stat_q & mask_q);

   // ---------------------------------------------------------------
   // Analog front-end drive
   // ---------------------------------------------------------------
   // The comparator answer reaches the sequencer three system clocks after a trial
   // change, so even divide by four resolves each bit in time
   assign sample_hold = (state_q == SEQ_SAMPLE);
   assign conv_active = (state_q == SEQ_CONV);
   assign conv_channel = (state_q == SEQ_IDLE) ? 4'h0 : cur_ch;
   assign sar_trial = code_q;

endmodule

// *** design/adp_pkg.sv ***
// Shared constants, register map and helpers of the converter pair sequencer
package adp_pkg;

   // ---------------------------------------------------------------
   // Widths and timing
   // ---------------------------------------------------------------
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;
   localparam int RES_W = 10;
   localparam int DIV_W = 3;
   localparam int CNT_W = 5;
   localparam int SEL_W = 3;
   localparam logic [1:0] SAMPLE_CLKS = 2'h2;
   localparam logic [3:0] MSB_INDEX = 4'h9;
   localparam logic [RES_W-1:0] RES_ZERO = 10'h000;

   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_STAT = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_MASK = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_PEND = 8'h0c;
   localparam logic [2:0] PAIR_BLOCK = 3'h1;
   localparam logic [1:0] RES_BLOCK = 2'h1;

   // ---------------------------------------------------------------
   // Field layouts and reset values
   // ---------------------------------------------------------------
   localparam int CTRL_ON_BIT = 15;
   localparam int CTRL_PLL_BIT = 8;
   localparam int CTRL_DIV_LSB = 0;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_WMASK = 16'h8107;
   localparam int PCFG_EN_BIT = 7;
   localparam int PCFG_SEL_LSB = 0;
   localparam logic [7:0] PCFG_RESET = 8'h00;
   localparam logic [7:0] PCFG_WMASK = 8'h87;

   // ---------------------------------------------------------------
   // Converter clock divisor
   // ---------------------------------------------------------------
   localparam logic [DIV_W-1:0] PLL_MIN_CODE = 3'h2;
   localparam logic [DIV_W-1:0] PLL_FALLBACK_CODE = 3'h2;
   localparam logic [CNT_W-1:0] DIV_BASE = 5'h04;

   typedef enum logic [1:0] {SEQ_IDLE, SEQ_SAMPLE, SEQ_CONV} adp_seq_state_type;

   // Code n divides by 4 + 2n; with the PLL the two fastest codes fall back
   function automatic logic [CNT_W-1:0] adp_div_ratio(input logic [DIV_W-1:0] code, input logic pll);
      logic [DIV_W-1:0] eff;
      eff = (pll && (code < PLL_MIN_CODE)) ? PLL_FALLBACK_CODE : code;
      return DIV_BASE + {1'b0, eff, 1'b0};
   endfunction

endpackage

// *** design/adp_clkdiv.sv ***
// Converter clock divider producing one-cycle converter clock enables
`timescale 1ns/1ps
module adp_clkdiv
   import adp_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic converter_on,
   input wire logic pll_in_use,
   input wire logic [DIV_W-1:0] conv_clock_divisor,
   output logic conv_tick
);

   logic [CNT_W-1:0] cnt_q;
   logic [CNT_W-1:0] cnt_d;
   wire logic [CNT_W-1:0] ratio;
   wire logic at_end;

   assign ratio = adp_div_ratio(conv_clock_divisor, pll_in_use);
   // Compare with >= so a shrinking divisor cannot make the counter run past its end
   assign at_end = (cnt_q >= (ratio - CNT_W'(1)));
   assign conv_tick = converter_on & at_end;
   assign cnt_d = at_end ? '0 : cnt_q + CNT_W'(1);

   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         cnt_q <= '0;
      end else if (!converter_on) begin
         cnt_q <= '0;
      end else begin
         cnt_q <= cnt_d;
      end
   end

endmodule

// *** verification/adp_partner.sv ***
// Partner model: trigger sources and analog channel levels
`timescale 1ns/1ps
module adp_partner
   import adp_pkg::*;
#(
   parameter int NUM_TRIG = 8
)
(
   input wire logic sys_clk,
   input wire logic [NUM_TRIG-1:0] fire,
   input wire logic [3:0] conv_channel,
   input wire logic [RES_W-1:0] sar_trial,
   output logic [NUM_TRIG-1:0] trig_in,
   output logic comp_in
);
   logic [NUM_TRIG-1:0] f1_q, f2_q, f3_q;
   logic [RES_W-1:0] level;
   // Stretch each request so the three-stage synchroniser sees it; bench spaces them
   always_ff @(posedge sys_clk) begin
      f1_q <= fire;
      f2_q <= f1_q;
      f3_q <= f2_q;
   end
   assign trig_in = f1_q | f2_q | f3_q;
   assign level = 10'h155 + 10'h049 * {6'h00, conv_channel};
   assign comp_in = level >= sar_trial;
endmodule

// *** verification/adp_chk.sv ***
// Checker of the pair sequencer ports, bound to the top module
`timescale 1ns/1ps
module adp_chk
   import adp_pkg::*;
#(
   parameter int NUM_PAIRS = 6,
   parameter int NUM_TRIG = 8
)
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [DATA_W-1:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   input wire logic [DATA_W-1:0] avs_readdata,
   input wire logic avs_waitrequest,
   input wire logic [NUM_TRIG-1:0] trig_in,
   input wire logic comp_in,
   input wire logic sample_hold,
   input wire logic conv_active,
   input wire logic [3:0] conv_channel,
   input wire logic [RES_W-1:0] sar_trial,
   input wire logic irq
);
   // ----
   // Shadow of control and mask, phase counters
   // ----
   logic on_q, pll_q;
   logic [DIV_W-1:0] div_q;
   logic [NUM_PAIRS-1:0] mask_q;
   logic [9:0] sh_q, cv_q;
   logic [5:0] ratio;
   wire wr_ctrl = avs_write && avs_address == OFS_CTRL;
   wire wr_mask = avs_write && avs_address == OFS_MASK && avs_byteenable[0];
   assign ratio = (pll_q && div_q < 3'h2) ? 6'h08 : 6'h04 + {2'h0, div_q, 1'b0};
   always_ff @(posedge sys_clk or posedge rst) begin
      if (rst) begin
         {on_q, pll_q, div_q, mask_q, sh_q, cv_q} <= '0;
      end else begin
         if (wr_ctrl && avs_byteenable[0]) div_q <= avs_writedata[2:0];
         if (wr_ctrl && avs_byteenable[1]) {on_q, pll_q} <= {avs_writedata[15], avs_writedata[8]};
         if (wr_mask) mask_q <= avs_writedata[NUM_PAIRS-1:0];
         sh_q <= sample_hold ? sh_q + 10'h001 : 10'h000;
         cv_q <= conv_active ? cv_q + 10'h001 : 10'h000;
      end
   end
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   a_write_no_wait: assert property (avs_write |-> !avs_waitrequest)
      else $error("write was stalled");
   a_read_one_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
      else $error("read wait is not one cycle");
   a_sample_len: assert property ($fell(sample_hold) |-> sh_q == {3'h0, ratio, 1'b0})
      else $error("sample phase length wrong");
   a_conv_len: assert property ($fell(conv_active) |-> cv_q == {4'h0, ratio} * 10'h014)
      else $error("pair conversion length wrong");
   a_sample_then_conv: assert property ($fell(sample_hold) |-> conv_active)
      else $error("conversion did not follow sampling");
   a_no_overlap: assert property (!(sample_hold && conv_active))
      else $error("sampling and converting together");
   a_idle_channel: assert property (!(sample_hold || conv_active) |-> conv_channel == 4'h0)
      else $error("channel shown while idle");
   a_side_last: assert property ($fell(conv_active) |-> $past(conv_channel[0]))
      else $error("pair ended before second side");
   a_off_idle: assert property ((!on_q) [*3] |-> !sample_hold && !conv_active)
      else $error("sequencer active while off");
   a_irq_masked: assert property (mask_q == {NUM_PAIRS{1'b0}} |-> !irq)
      else $error("interrupt with all masked");
   c_pair_done: cover property ($fell(conv_active));
   c_irq: cover property ($rose(irq));
   c_read: cover property (avs_read && !avs_waitrequest);
endmodule

bind adp_top adp_chk #(.NUM_PAIRS(NUM_PAIRS), .NUM_TRIG(NUM_TRIG)) adp_chk_i (
   .sys_clk(sys_clk), .rst(rst), .avs_address(avs_address), .avs_read(avs_read),
   .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
   .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .trig_in(trig_in),
   .comp_in(comp_in), .sample_hold(sample_hold), .conv_active(conv_active),
   .conv_channel(conv_channel), .sar_trial(sar_trial), .irq(irq));

// *** verification/tb.sv ***
// Testbench: register tasks and conversion scenarios of the pair sequencer
`timescale 1ns/1ps
module tb
   import adp_pkg::*;
();
   logic sys_clk = 1'b0;
   logic rst = 1'b1;
   logic [ADDR_W-1:0] avs_address = '0;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [DATA_W-1:0] avs_writedata = '0;
   logic [3:0] avs_byteenable = 4'hf;
   logic [DATA_W-1:0] avs_readdata, rd_data;
   logic avs_waitrequest, comp_in, sample_hold, conv_active, irq, sh_prev = 1'b0;
   logic [3:0] conv_channel;
   logic [RES_W-1:0] sar_trial;
   logic [7:0] trig_in;
   logic [7:0] fire = 8'h00;
   int failures = 0, cmp_count = 0, cycles = 0, sh_cyc = 0, cv_cyc = 0, sh_rise = 0;

   adp_top #(.NUM_PAIRS(6), .NUM_TRIG(8)) adp_top_i (.sys_clk(sys_clk), .rst(rst),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .trig_in(trig_in), .comp_in(comp_in),
      .sample_hold(sample_hold), .conv_active(conv_active), .conv_channel(conv_channel),
      .sar_trial(sar_trial), .irq(irq));
   adp_partner #(.NUM_TRIG(8)) adp_partner_i (.sys_clk(sys_clk), .fire(fire),
      .conv_channel(conv_channel), .sar_trial(sar_trial), .trig_in(trig_in), .comp_in(comp_in));

   initial forever #50 sys_clk = ~sys_clk;

   // ----
   // Phase monitor and timeout; whole run needs well under 8000 cycles
   // ----
   always @(posedge sys_clk) begin
      cycles <= cycles + 1;
      sh_prev <= sample_hold;
      if (sample_hold === 1'b1) sh_cyc <= sh_cyc + 1;
      if (conv_active === 1'b1) cv_cyc <= cv_cyc + 1;
      if (sample_hold === 1'b1 && sh_prev === 1'b0) sh_rise <= sh_rise + 1;
      if (cycles == 20000) begin
         failures = failures + 1;
         results();
      end
   end

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      avs_write <= 1'b0;
      @(posedge sys_clk);
   endtask

   task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input bit cmp = 1'b1);
      avs_address <= a;
      avs_read <= 1'b1;
      do @(posedge sys_clk); while (avs_waitrequest !== 1'b0);
      rd_data = avs_readdata;
      avs_read <= 1'b0;
      @(posedge sys_clk);
      if (cmp) chk(rd_data, exp);
   endtask

   task automatic pulse(input logic [7:0] t);
      fire <= t;
      @(posedge sys_clk);
      fire <= 8'h00;
      @(posedge sys_clk);
   endtask

   task automatic settle();
      int n;
      n = 0;
      while ((sample_hold !== 1'b0 || conv_active !== 1'b0) && n < 1000) begin
         @(posedge sys_clk);
         n++;
      end
   endtask

   task automatic results();
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask

   function automatic int ratio(input int p, input int c);
      return (p == 1 && c < 2) ? 8 : 4 + 2 * c;
   endfunction

   function automatic logic [31:0] val(input int c);
      return 32'h155 + 32'h49 * c;
   endfunction

   initial begin
      int r, s0, v0, n;
      logic [31:0] st;
      repeat (2) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      rdc(OFS_CTRL, 32'h0);
      wr(8'h80, 32'hffff_ffff);
      rdc(8'h80, 32'h0);
      wr(OFS_CTRL, 32'h0000_7ef8);
      rdc(OFS_CTRL, 32'h0);
      wr(8'h20, 32'h80);
      wr(8'h24, 32'h81);
      wr(OFS_MASK, 32'h3);
      $display("test registers done");
      // Divisor only changes with the converter off, then it is switched on
      for (int p = 0; p < 2; p++) begin
         for (int c = 0; c < 8; c++) begin
            r = ratio(p, c);
            wr(OFS_CTRL, 32'(p * 256 + c));
            wr(OFS_CTRL, 32'(p * 256 + c + 32768));
            s0 = sh_cyc;
            v0 = cv_cyc;
            pulse(8'h01);
            n = 0;
            while (irq !== 1'b1 && n < 2000) begin
               @(posedge sys_clk);
               n++;
            end
            settle();
            repeat (2) @(posedge sys_clk);
            chk(sh_cyc - s0, 2 * r);
            chk(cv_cyc - v0, 20 * r);
            rdc(OFS_STAT, 32'h1);
            chk(irq, 1'b0);
            // Three synchroniser stages still leave divide by four time for each bit
            rdc(8'h40, val(0));
            rdc(8'h44, val(1));
            wr(OFS_CTRL, 32'h0);
         end
      end
      $display("test divisors done");
      wr(OFS_CTRL, 32'h3);
      wr(OFS_CTRL, 32'h8003);
      s0 = sh_rise;
      pulse(8'h03);
      repeat (30) @(posedge sys_clk);
      pulse(8'h02);
      st = 32'h0;
      n = 0;
      while (st !== 32'h3 && n < 100) begin
         rdc(OFS_STAT, 32'h0, 1'b0);
         st = st | rd_data;
         repeat (10) @(posedge sys_clk);
         n++;
      end
      chk(st, 32'h3);
      repeat (300) @(posedge sys_clk);
      chk(sh_rise - s0, 2);
      rdc(8'h48, val(2));
      rdc(8'h4c, val(3));
      $display("test queue done");
      wr(OFS_MASK, 32'h0);
      pulse(8'h01);
      repeat (30) @(posedge sys_clk);
      settle();
      chk(irq, 1'b0);
      wr(OFS_MASK, 32'h1);
      chk(irq, 1'b1);
      rdc(OFS_STAT, 32'h1);
      chk(irq, 1'b0);
      $display("test interrupt done");
      wr(OFS_CTRL, 32'h3);
      s0 = sh_rise;
      pulse(8'h01);
      repeat (100) @(posedge sys_clk);
      chk(sh_rise - s0, 0);
      rdc(OFS_PEND, 32'h0);
      rdc(OFS_STAT, 32'h0);
      $display("test off done");
      results();
   end
endmodule
